/* core/ditm_monitor.sv */
// drive input terminal monitor: reference loss, input filter, function map
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ditm_defs.svh"
module ditm_monitor #(
   parameter int NIN = 11,
   parameter int MS_CYCLES = `DITM_MS_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [7:0] prog_input,
   input wire logic [2:0] subboard_input,
   input wire logic subboard_fitted,
   input wire logic [15:0] volt_level,
   input wire logic [15:0] curr_level,
   input wire logic [15:0] pulse_level,
   output logic coast_on_loss,
   output logic ramp_stop,
   output logic [1:0] fault_code,
   output logic [3:0] step_index,
   output logic jog_active,
   output logic [15:0] jog_freq,
   output logic run_fwd,
   output logic run_rev,
   output logic fault_reset,
   output logic emergency_stop_input
);
   // only eleven terminals and a nonzero tick period are served
   if (NIN != 11 || MS_CYCLES < 1)
   begin : g_param_check
      $error("unsupported parameters");
   end
   typedef struct packed {
      ditm_pkg::ditm_src_t src;
      ditm_pkg::ditm_crit_t crit;
      ditm_pkg::ditm_react_t react;
      logic [15:0] timeout;
      logic [15:0] vmin;
      logic [15:0] imin;
      logic [15:0] pmin;
      logic [15:0] filt;
      logic [15:0] jog;
      logic [47:0] func;
      logic [2:0] sel;
      ditm_pkg::ditm_state_t st;
      ditm_pkg::ditm_fault_t flt;
      logic [31:0] ms_cnt;
      logic ms_tick;
      logic [6:0] tenth_cnt;
      logic [15:0] loss_cnt;
      logic [10:0][15:0] filt_cnt;
      logic [10:0] filt_out;
      logic [15:0] rdata;
   } ditm_state_s_t;
   ditm_state_s_t s_q;
   ditm_state_s_t s_d;
   logic [10:0] raw_in;
   logic [10:0] status;
   logic [15:0] level;
   logic [15:0] thresh;
   logic below;
   logic checking;
   logic fn_active [0:63];
   // sub-board inputs masked when absent
   assign raw_in = {subboard_input & {3{subboard_fitted}}, prog_input};
   assign status = s_q.filt_out;
   // decode active functions from mapped, filtered main inputs
   always_comb
   begin
      for (int f = 0; f < 64; f++) fn_active[f] = 1'b0;
      for (int k = 0; k < 8; k++)
         fn_active[s_q.func[k*6 +: 6]] = fn_active[s_q.func[k*6 +: 6]] | s_q.filt_out[k];
   end
   assign emergency_stop_input = fn_active[ditm_pkg::DITM_FN_ESTOP];
   assign jog_active = fn_active[ditm_pkg::DITM_FN_JOG];
   assign fault_reset = fn_active[ditm_pkg::DITM_FN_RESET];
   assign run_fwd = fn_active[ditm_pkg::DITM_FN_FWD];
   assign run_rev = fn_active[ditm_pkg::DITM_FN_REV];
   // jog overrides the step selection
   assign step_index = jog_active ? 4'h0 :
      {fn_active[ditm_pkg::DITM_FN_SPD_X], fn_active[ditm_pkg::DITM_FN_SPD_H],
       fn_active[ditm_pkg::DITM_FN_SPD_M], fn_active[ditm_pkg::DITM_FN_SPD_L]};
   assign jog_freq = s_q.jog;
   // pick the monitored level; volt+current watches voltage only
   always_comb
   begin
      checking = 1'b1;
      level = volt_level;
      thresh = s_q.vmin;
      case (s_q.src)
         ditm_pkg::DITM_SRC_VOLT, ditm_pkg::DITM_SRC_VOLT_SIGNED, ditm_pkg::DITM_SRC_VOLT_CURR:
         begin
            level = volt_level;
            thresh = s_q.vmin;
         end
         ditm_pkg::DITM_SRC_CURR:
         begin
            level = curr_level;
            thresh = s_q.imin;
         end
         ditm_pkg::DITM_SRC_PULSE:
         begin
            level = pulse_level;
            thresh = s_q.pmin;
         end
         default: checking = 1'b0;
      endcase
      case (s_q.crit)
         ditm_pkg::DITM_CRIT_HALF: below = checking && level < {1'b0, thresh[15:1]};
         ditm_pkg::DITM_CRIT_BELOW: below = checking && level < thresh;
         default: below = 1'b0;
      endcase
   end
   // next state: registers, filter, timers and loss machine
   always_comb
   begin
      s_d = s_q;
      s_d.rdata = 16'h0000;
      s_d.ms_tick = 1'b0;
      if (s_q.ms_cnt >= 32'(MS_CYCLES - 1))
      begin
         s_d.ms_cnt = 32'h0;
         s_d.ms_tick = 1'b1;
      end
      else
      begin
         s_d.ms_cnt = s_q.ms_cnt + 32'h1;
      end
      // one time constant for all eleven inputs, counted in ms
      for (int k = 0; k < 11; k++)
      begin
         if (raw_in[k] == s_q.filt_out[k])
            s_d.filt_cnt[k] = 16'h0;
         else if (s_q.ms_tick)
         begin
            if (s_q.filt_cnt[k] >= s_q.filt)
            begin
               s_d.filt_out[k] = raw_in[k];
               s_d.filt_cnt[k] = 16'h0;
            end
            else
               s_d.filt_cnt[k] = s_q.filt_cnt[k] + 16'h1;
         end
      end
      // loss timing in tenths of a second
      case (s_q.st)
         ditm_pkg::DITM_ST_OK:
         begin
            s_d.tenth_cnt = 7'h0;
            s_d.loss_cnt = 16'h0;
            if (below) s_d.st = ditm_pkg::DITM_ST_PEND;
         end
         ditm_pkg::DITM_ST_PEND:
         begin
            if (!below)
               s_d.st = ditm_pkg::DITM_ST_OK;
            else if (s_q.loss_cnt >= s_q.timeout)
            begin
               s_d.st = ditm_pkg::DITM_ST_LOST;
               case (s_q.src)
                  ditm_pkg::DITM_SRC_CURR: s_d.flt = ditm_pkg::DITM_FLT_CURR;
                  ditm_pkg::DITM_SRC_PULSE: s_d.flt = ditm_pkg::DITM_FLT_PULSE;
                  default: s_d.flt = ditm_pkg::DITM_FLT_VOLT;
               endcase
            end
            else if (s_q.ms_tick)
            begin
               if (s_q.tenth_cnt >= `DITM_TENTH_MS - 7'd1)
               begin
                  s_d.tenth_cnt = 7'h0;
                  s_d.loss_cnt = s_q.loss_cnt + 16'h1;
               end
               else
                  s_d.tenth_cnt = s_q.tenth_cnt + 7'h1;
            end
         end
         ditm_pkg::DITM_ST_LOST:
         begin
            // latched until fault reset input
            if (fault_reset)
            begin
               s_d.st = ditm_pkg::DITM_ST_OK;
               s_d.flt = ditm_pkg::DITM_FLT_NONE;
            end
         end
         default: s_d.st = ditm_pkg::DITM_ST_OK;
      endcase
      // register writes, blocked during emergency stop
      if (reg_wr && !emergency_stop_input)
      begin
         case (reg_addr)
            `DITM_REG_SOURCE: s_d.src = ditm_pkg::ditm_src_t'(reg_wdata[2:0]);
            `DITM_REG_CRIT: s_d.crit = ditm_pkg::ditm_crit_t'(reg_wdata[1:0]);
            `DITM_REG_REACT: s_d.react = ditm_pkg::ditm_react_t'(reg_wdata[1:0]);
            `DITM_REG_TIMEOUT: s_d.timeout = reg_wdata;
            `DITM_REG_VMIN: s_d.vmin = reg_wdata;
            `DITM_REG_IMIN: s_d.imin = reg_wdata;
            `DITM_REG_PMIN: s_d.pmin = reg_wdata;
            `DITM_REG_FILT: s_d.filt = reg_wdata;
            `DITM_REG_JOG: s_d.jog = reg_wdata;
            `DITM_REG_SELECT: s_d.sel = reg_wdata[2:0];
            `DITM_REG_FUNC: s_d.func[s_q.sel*6 +: 6] = reg_wdata[5:0];
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            `DITM_REG_STATUS: s_d.rdata = {5'h00, status};
            `DITM_REG_SOURCE: s_d.rdata = {13'h0000, s_q.src};
            `DITM_REG_CRIT: s_d.rdata = {14'h0000, s_q.crit};
            `DITM_REG_REACT: s_d.rdata = {14'h0000, s_q.react};
            `DITM_REG_TIMEOUT: s_d.rdata = s_q.timeout;
            `DITM_REG_VMIN: s_d.rdata = s_q.vmin;
            `DITM_REG_IMIN: s_d.rdata = s_q.imin;
            `DITM_REG_PMIN: s_d.rdata = s_q.pmin;
            `DITM_REG_FILT: s_d.rdata = s_q.filt;
            `DITM_REG_JOG: s_d.rdata = s_q.jog;
            `DITM_REG_SELECT: s_d.rdata = {13'h0000, s_q.sel};
            `DITM_REG_FUNC: s_d.rdata = {10'h000, s_q.func[s_q.sel*6 +: 6]};
            `DITM_REG_FAULT: s_d.rdata = {13'h0000, s_q.st == ditm_pkg::DITM_ST_LOST, s_q.flt};
            default: s_d.rdata = 16'h0000;
         endcase
      end
   end
   // state register with synchronous reset and global enable
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.timeout <= `DITM_TIMEOUT_RST;
         s_q.filt <= `DITM_FILT_RST;
         s_q.jog <= `DITM_JOG_RST;
         s_q.func <= `DITM_FUNC_RST;
      end
      else if (clk_en)
         s_q <= s_d;
   end
   assign reg_rdata = s_q.rdata;
   assign fault_code = s_q.flt;
   // reaction once loss is declared; none keeps running
   assign coast_on_loss = s_q.st == ditm_pkg::DITM_ST_LOST && s_q.react == ditm_pkg::DITM_REACT_COAST;
   assign ramp_stop = s_q.st == ditm_pkg::DITM_ST_LOST && s_q.react == ditm_pkg::DITM_REACT_STOP;

   a_write_block_estop: assert property (@(posedge mclk) disable iff (sys_rst)
      (clk_en && reg_wr && emergency_stop_input && reg_addr == `DITM_REG_JOG) |=> $stable(s_q.jog))
      else $error("write accepted during emergency stop");
   a_recover_restart: assert property (@(posedge mclk) disable iff (sys_rst)
      (clk_en && s_q.st == ditm_pkg::DITM_ST_PEND && !below) |=> s_q.st == ditm_pkg::DITM_ST_OK)
      else $error("loss timer not restarted");
   a_coast_on_loss: assert property (@(posedge mclk) disable iff (sys_rst)
      (s_q.st == ditm_pkg::DITM_ST_LOST && s_q.react == ditm_pkg::DITM_REACT_COAST) |-> coast_on_loss && !ramp_stop
       && fault_code != ditm_pkg::DITM_FLT_NONE)
      else $error("coast not applied");
   a_no_check_keypad: assert property (@(posedge mclk) disable iff (sys_rst)
      (s_q.src == ditm_pkg::DITM_SRC_KEYPAD) |-> !below)
      else $error("checking on non-analog source");
   a_jog_override: assert property (@(posedge mclk) disable iff (sys_rst)
      jog_active |-> step_index == 4'h0)
      else $error("jog did not override steps");
   a_subboard_mask: assert property (@(posedge mclk) disable iff (sys_rst)
      (!subboard_fitted && clk_en && status[10:8] == 3'h0) |=> status[10:8] == 3'h0)
      else $error("sub-board input shown while absent");
   a_loss_after_timeout: assert property (@(posedge mclk) disable iff (sys_rst)
      (clk_en && s_q.st == ditm_pkg::DITM_ST_PEND && s_q.loss_cnt < s_q.timeout)
       |=> s_q.st != ditm_pkg::DITM_ST_LOST)
      else $error("loss declared without waiting");
   a_fault_code_src: assert property (@(posedge mclk) disable iff (sys_rst)
      (clk_en && s_q.st == ditm_pkg::DITM_ST_PEND && below && s_q.loss_cnt >= s_q.timeout
       && s_q.src == ditm_pkg::DITM_SRC_PULSE) |=> fault_code == ditm_pkg::DITM_FLT_PULSE)
      else $error("wrong fault code");
   a_main_volt_only: assert property (@(posedge mclk) disable iff (sys_rst)
      (s_q.src == ditm_pkg::DITM_SRC_VOLT_CURR && volt_level >= s_q.vmin) |-> !below)
      else $error("current input watched with voltage main reference");
   a_crit_none_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (s_q.crit == ditm_pkg::DITM_CRIT_NONE) |-> !below)
      else $error("loss flagged with checking disabled");
   a_below_min_only: assert property (@(posedge mclk) disable iff (sys_rst)
      (s_q.src == ditm_pkg::DITM_SRC_CURR && curr_level >= s_q.imin) |-> !below)
      else $error("loss flagged above the minimum point");
endmodule // ditm_monitor

/* core/ditm_defs.svh */
// constants for the drive input terminal monitor
`ifndef DITM_DEFS_SVH
`define DITM_DEFS_SVH
// register indices
`define DITM_REG_STATUS 4'h0
`define DITM_REG_SOURCE 4'h1
`define DITM_REG_CRIT 4'h2
`define DITM_REG_REACT 4'h3
`define DITM_REG_TIMEOUT 4'h4
`define DITM_REG_VMIN 4'h5
`define DITM_REG_IMIN 4'h6
`define DITM_REG_PMIN 4'h7
`define DITM_REG_FILT 4'h8
`define DITM_REG_JOG 4'h9
`define DITM_REG_FUNC 4'hA
`define DITM_REG_FAULT 4'hB
`define DITM_REG_SELECT 4'hC
// timeout in tenths of a second, factory 1.0 s
`define DITM_TIMEOUT_RST 16'h000A
// ticks per millisecond at 100 MHz
`define DITM_MS_NS 1000000
`define DITM_CLK_NS 10
`define DITM_MS_CYCLES (`DITM_MS_NS / `DITM_CLK_NS)
// tenth of a second in milliseconds
`define DITM_TENTH_MS 7'd100
// filter default, ms
`define DITM_FILT_RST 16'h000A
// jog frequency in 0.01 Hz, factory 10.00 Hz
`define DITM_JOG_RST 16'h03E8
// default input function map, 6 bits per input, input 1 in the low field
// inputs 1..8 = 00, 01, 02, 1B, 1C, 1D, 29, 2A packed six bits apiece
`define DITM_FUNC_RST 48'hAA97_5C6C_2040
`endif

/* core/ditm_pkg.sv */
// types for the drive input terminal monitor
package ditm_pkg;
   typedef enum logic [2:0] {
      DITM_SRC_KEYPAD = 3'h0,
      DITM_SRC_VOLT = 3'h1,
      DITM_SRC_VOLT_SIGNED = 3'h2,
      DITM_SRC_CURR = 3'h3,
      DITM_SRC_VOLT_CURR = 3'h4,
      DITM_SRC_PULSE = 3'h5,
      DITM_SRC_COMM = 3'h6
   } ditm_src_t;
   typedef enum logic [1:0] {
      DITM_CRIT_NONE = 2'h0,
      DITM_CRIT_HALF = 2'h1,
      DITM_CRIT_BELOW = 2'h2
   } ditm_crit_t;
   typedef enum logic [1:0] {
      DITM_REACT_NONE = 2'h0,
      DITM_REACT_COAST = 2'h1,
      DITM_REACT_STOP = 2'h2
   } ditm_react_t;
   typedef enum logic [1:0] {
      DITM_ST_OK = 2'h0,
      DITM_ST_PEND = 2'h1,
      DITM_ST_LOST = 2'h2
   } ditm_state_t;
   typedef enum logic [1:0] {
      DITM_FLT_NONE = 2'h0,
      DITM_FLT_VOLT = 2'h1,
      DITM_FLT_CURR = 2'h2,
      DITM_FLT_PULSE = 2'h3
   } ditm_fault_t;
   // function codes
   typedef enum logic [5:0] {
      DITM_FN_SPD_L = 6'h00,
      DITM_FN_SPD_M = 6'h01,
      DITM_FN_SPD_H = 6'h02,
      DITM_FN_SPD_X = 6'h1A,
      DITM_FN_RESET = 6'h1B,
      DITM_FN_ESTOP = 6'h1C,
      DITM_FN_JOG = 6'h1D,
      DITM_FN_FWD = 6'h69,
      DITM_FN_REV = 6'h6A
   } ditm_fn_t;
endpackage

/* sim/ditm_field.sv */
// field switches and reference sensors in front of the monitor
`timescale 1ns/1ps
module ditm_field (
   input wire logic mclk,
   input wire logic [10:0] sw_req,
   input wire logic [47:0] lvl_req,
   output logic [7:0] prog_input,
   output logic [2:0] subboard_input,
   output logic [15:0] volt_level,
   output logic [15:0] curr_level,
   output logic [15:0] pulse_level
);
   logic [10:0] sw_q = 11'h000;
   logic [2:0] bounce_q = 3'h0;
   // contacts chatter a few cycles after each change, so the filter has work
   always_ff @(posedge mclk)
   begin
      if (sw_req != sw_q && bounce_q == 3'h0)
         bounce_q <= 3'h5;
      else if (bounce_q != 3'h0)
         bounce_q <= bounce_q - 3'h1;
      if (bounce_q == 3'h1)
         sw_q <= sw_req;
   end
   // odd bounce counts show the new level, even ones the old
   assign {subboard_input, prog_input} = bounce_q[0] ? sw_req : sw_q;
   assign {pulse_level, curr_level, volt_level} = lvl_req;
endmodule // ditm_field

/* sim/ditm_monitor_tb.sv */
// self-checking bench for the drive input terminal monitor
`timescale 1ns/1ps
`include "ditm_defs.svh"
module ditm_monitor_tb;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic subboard_fitted = 1'b0;
   logic [10:0] sw_req = 11'h000;
   logic [47:0] lvl_req = {3{16'h0200}};
   logic [15:0] reg_rdata, volt_level, curr_level, pulse_level, jog_freq;
   logic [7:0] prog_input;
   logic [2:0] subboard_input;
   logic [3:0] step_index;
   logic [1:0] fault_code;
   logic coast_on_loss, ramp_stop, jog_active, run_fwd, run_rev, fault_reset, emergency_stop_input;
   logic [15:0] exp_q[$];
   logic rd_pend = 1'b0;
   logic [31:0] rng = 32'h53FF;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   // expected {step, jog, fwd, rev, reset, estop} for each input alone
   logic [8:0] map_exp [8] = '{9'h020, 9'h040, 9'h080, 9'h002, 9'h001, 9'h010, 9'h008, 9'h004};

   ditm_monitor #(.NIN(11), .MS_CYCLES(10)) uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .prog_input(prog_input), .subboard_input(subboard_input), .subboard_fitted(subboard_fitted),
      .volt_level(volt_level), .curr_level(curr_level), .pulse_level(pulse_level),
      .coast_on_loss(coast_on_loss), .ramp_stop(ramp_stop), .fault_code(fault_code), .step_index(step_index),
      .jog_active(jog_active), .jog_freq(jog_freq), .run_fwd(run_fwd), .run_rev(run_rev),
      .fault_reset(fault_reset), .emergency_stop_input(emergency_stop_input));
   ditm_field field (.mclk(mclk), .sw_req(sw_req), .lvl_req(lvl_req), .prog_input(prog_input),
      .subboard_input(subboard_input), .volt_level(volt_level), .curr_level(curr_level),
      .pulse_level(pulse_level));

   // 100 MHz control clock
   always #5 mclk = ~mclk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // gap cycle after each strobe keeps one assignment per signal per step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask

   // long enough for bounce plus a two millisecond filter
   task automatic set_sw(input logic [10:0] v);
      sw_req <= v;
      repeat (48) @(posedge mclk);
   endtask

   task automatic outs(input logic [8:0] e);
      @(negedge mclk);
      chk("outputs", {7'h00, e}, {7'h00, step_index, jog_active, run_fwd, run_rev, fault_reset,
         emergency_stop_input});
      @(posedge mclk);
   endtask

   task automatic fault_chk(input logic [1:0] fc, input logic [1:0] rc);
      @(negedge mclk);
      chk("fault_code", {14'h0000, fc}, {14'h0000, fault_code});
      chk("reaction", {14'h0000, rc}, {14'h0000, coast_on_loss, ramp_stop});
      @(posedge mclk);
   endtask

   // drop one reference, then look just before and just after the timeout
   task automatic loss(input ditm_pkg::ditm_src_t src, input ditm_pkg::ditm_crit_t crt,
         input ditm_pkg::ditm_react_t rct, input int sel, input logic [15:0] lv, input logic [1:0] fc);
      logic [47:0] l;
      l = {3{16'h0200}};
      l[sel*16 +: 16] = lv;
      wr(`DITM_REG_SOURCE, {13'h0000, src});
      wr(`DITM_REG_CRIT, {14'h0000, crt});
      wr(`DITM_REG_REACT, {14'h0000, rct});
      lvl_req <= l;
      repeat (900) @(posedge mclk);
      fault_chk(2'h0, 2'h0);
      repeat (300) @(posedge mclk);
      fault_chk(fc, {fc != 2'h0 && rct == ditm_pkg::DITM_REACT_COAST, fc != 2'h0 && rct == ditm_pkg::DITM_REACT_STOP});
      rd(`DITM_REG_FAULT, {13'h0000, fc != 2'h0, fc});
      lvl_req <= {3{16'h0200}};
      set_sw(11'h008);
      set_sw(11'h000);
      fault_chk(2'h0, 2'h0);
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge mclk) rd_pend <= reg_rd;
   always @(negedge mclk)
   begin
      if (rd_pend)
         chk("read data", exp_q.size() > 0 ? exp_q.pop_front() : 16'hDEAD, reg_rdata);
   end

   // hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         failures++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(`DITM_REG_TIMEOUT, 16'h000A);
      rd(`DITM_REG_FILT, 16'h000A);
      rd(`DITM_REG_JOG, 16'h03E8);
      chk("jog_freq", 16'h03E8, jog_freq);
      wr(`DITM_REG_STATUS, 16'hFFFF);
      rd(`DITM_REG_STATUS, 16'h0000);
      rd(4'hF, 16'h0000);
      // line exchange setting above 100 ms must be accepted
      wr(`DITM_REG_FILT, 16'h0065);
      rd(`DITM_REG_FILT, 16'h0065);
      wr(`DITM_REG_FILT, 16'h0002);
      for (int i = 0; i < 8; i++)
      begin
         set_sw(11'h001 << i);
         outs(map_exp[i]);
      end
      set_sw(11'h027);
      outs(9'h010);
      wr(`DITM_REG_SELECT, 16'h0007);
      wr(`DITM_REG_FUNC, 16'h001A);
      rd(`DITM_REG_FUNC, 16'h001A);
      set_sw(11'h080);
      outs(9'h100);
      wr(`DITM_REG_FUNC, 16'h006A);
      set_sw(11'h010);
      wr(`DITM_REG_JOG, 16'h1234);
      rd(`DITM_REG_JOG, 16'h03E8);
      set_sw(11'h000);
      wr(`DITM_REG_JOG, 16'h1234);
      rd(`DITM_REG_JOG, 16'h1234);
      chk("jog_freq", 16'h1234, jog_freq);
      // enable low freezes all state, so a write then is lost
      clk_en <= 1'b0;
      wr(`DITM_REG_JOG, 16'h5555);
      clk_en <= 1'b1;
      rd(`DITM_REG_JOG, 16'h1234);
      // random terminal patterns, sub-board absent and fitted in turn
      for (int k = 0; k < 4; k++)
      begin
         rng = xs(rng);
         subboard_fitted <= k[0];
         set_sw(rng[10:0]);
         rd(`DITM_REG_STATUS, k[0] ? {5'h00, rng[10:0]} : {8'h00, rng[7:0]});
      end
      set_sw(11'h000);
      wr(`DITM_REG_FILT, 16'h0008);
      sw_req <= 11'h001;
      repeat (60) @(posedge mclk);
      rd(`DITM_REG_STATUS, 16'h0000);
      repeat (60) @(posedge mclk);
      rd(`DITM_REG_STATUS, 16'h0001);
      wr(`DITM_REG_FILT, 16'h0002);
      set_sw(11'h000);
      wr(`DITM_REG_TIMEOUT, 16'h0001);
      wr(`DITM_REG_VMIN, 16'h0100);
      wr(`DITM_REG_IMIN, 16'h0100);
      wr(`DITM_REG_PMIN, 16'h0100);
      loss(ditm_pkg::DITM_SRC_VOLT, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_COAST, 0, 16'h00F0, 2'h1);
      loss(ditm_pkg::DITM_SRC_VOLT, ditm_pkg::DITM_CRIT_HALF, ditm_pkg::DITM_REACT_COAST, 0, 16'h0090, 2'h0);
      loss(ditm_pkg::DITM_SRC_VOLT_SIGNED, ditm_pkg::DITM_CRIT_HALF, ditm_pkg::DITM_REACT_NONE, 0, 16'h0070, 2'h1);
      loss(ditm_pkg::DITM_SRC_CURR, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_STOP, 1, 16'h00F0, 2'h2);
      loss(ditm_pkg::DITM_SRC_VOLT_CURR, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_COAST, 1, 16'h0000, 2'h0);
      loss(ditm_pkg::DITM_SRC_VOLT_CURR, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_STOP, 0, 16'h0000, 2'h1);
      loss(ditm_pkg::DITM_SRC_PULSE, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_STOP, 2, 16'h00F0, 2'h3);
      loss(ditm_pkg::DITM_SRC_KEYPAD, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_COAST, 0, 16'h0000, 2'h0);
      loss(ditm_pkg::DITM_SRC_COMM, ditm_pkg::DITM_CRIT_BELOW, ditm_pkg::DITM_REACT_COAST, 0, 16'h0000, 2'h0);
      loss(ditm_pkg::DITM_SRC_VOLT, ditm_pkg::DITM_CRIT_NONE, ditm_pkg::DITM_REACT_COAST, 0, 16'h0000, 2'h0);
      // a short recovery must restart the loss timer
      wr(`DITM_REG_CRIT, 16'h0002);
      wr(`DITM_REG_REACT, 16'h0000);
      lvl_req <= {32'h02000200, 16'h00F0};
      repeat (600) @(posedge mclk);
      lvl_req <= {3{16'h0200}};
      repeat (50) @(posedge mclk);
      lvl_req <= {32'h02000200, 16'h00F0};
      repeat (600) @(posedge mclk);
      fault_chk(2'h0, 2'h0);
      repeat (600) @(posedge mclk);
      fault_chk(2'h1, 2'h0);
      give_verdict();
   end
endmodule // ditm_monitor_tb
